// ---- src/mstd_pkg.sv ----
// Shared constants, register map and types of the motor stall detector.
package mstd_pkg;
   // ==========================================================================
   // Register map.
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] inrush_off = 8'h04;
   localparam logic [7:0] reg_off = 8'h08;
   localparam logic [7:0] cmd_off = 8'h0c;
   localparam logic [7:0] status_off = 8'h10;
   localparam logic [7:0] speed_off = 8'h14;
   // ==========================================================================
   // Control, command and status field positions.
   localparam int int_vref_bit = 0;
   localparam int stall_en_bit = 1;
   localparam int stall_response_select_bit = 2;
   localparam int report_bit = 3;
   localparam int softstart_bit = 4;
   localparam int current_reg_mode_lsb = 8;
   localparam int regctl_lsb = 12;
   localparam int scale_lsb = 16;
   localparam int clear_bit = 0;
   localparam int sleep_bit = 1;
   localparam int stall_flag_bit = 0;
   localparam int latched_bit = 1;
   localparam int blank_bit = 2;
   localparam int creg_bit = 3;
   localparam int sense_bit = 4;
   localparam int vref_bit = 5;
   // ==========================================================================
   // Reset values.
   localparam logic [15:0] inrush_rst = 16'h25b8;
   localparam logic [7:0] target_rst = 8'h00;
   localparam logic [1:0] current_reg_mode_rst = 2'h0;
   localparam logic [1:0] regctl_rst = 2'h0;
   localparam logic [1:0] scale_rst = 2'h0;
   // ==========================================================================
   // Timing.
   localparam real clk_mhz = 40.0;
   localparam real tick_us = 102.4;
   localparam real base_ms = 5.0;
   localparam real adc_khz = 80.0;
   localparam int tick_cyc = int'(tick_us * clk_mhz);
   localparam int base_cyc = int'(base_ms * 1000.0 * clk_mhz);
   localparam int adc_cyc = int'(clk_mhz * 1000.0 / adc_khz);
   // ==========================================================================
   // Modes and types.
   localparam logic [1:0] current_reg_mode_off = 2'h0;
   localparam logic [1:0] current_reg_mode_inrush = 2'h1;
   localparam logic [1:0] regctl_speed = 2'h2;
   localparam logic [1:0] regctl_volt = 2'h3;
   localparam logic [1:0] axi_okay = 2'h0;
   localparam logic [1:0] axi_slverr = 2'h2;
   typedef struct packed {
      logic [1:0] scale;
      logic [1:0] regctl;
      logic [1:0] current_reg_mode;
      logic softstart;
      logic report;
      logic stall_response_select;
      logic stall_en;
      logic int_vref;
   } mstd_ctrl_t;
   typedef enum logic [1:0] {mstd_blank, mstd_watch, mstd_stalled} mstd_state_t;
endpackage

// ---- src/mstd_top.sv ----
// Stall detector with inrush blanking, stall response, fault pin and AXI4-Lite registers.
//
// Summary of operation
// - Reference is external pin or internal 3 V.
// - Qualified stall sets the stall flag.
// - Enable bit gates all stall detection.
// - Disabled stall, mode 01: regulate always above trip.
// - Stall means sense at or above reference.
// - Sixteen bit field blanks stall during inrush.
// - After blanking, flag stall immediately on trip.
// - Interval is 5 ms plus 102.4 us per count; the timer adds one 102.4 us tick more.
// - Soft-start ramps target over inrush interval; the softstart bit is only stored and read back, nothing ramps.
// - Restart blanking on power-up, faults, sleep, stall.
// - Response bit 0 latches bridge outputs off.
// - Response bit 1 only flags, bridge keeps driving.
// - Clear-fault write clears flag and latch.
// - After clear, blank again then redetect.
// - Report bit drives fault pin low on stall.
// - Target field and two bit speed scale.
// - Speed mode compares estimate against target.
// - Regulation converter sampled at 80 kHz.
// - Mode 01 with stall enabled regulates during inrush.
// - Code 10 speed, code 11 voltage regulation.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mstd_top #(
   parameter int tick_cycles = mstd_pkg::tick_cyc,
   parameter int base_cycles = mstd_pkg::base_cyc
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic sense_ge_ext_ref,
   input wire logic sense_ge_int_ref,
   input wire logic fault_event,
   input wire logic [7:0] speed_estimate,
   output logic ref_internal_sel,
   output logic bridge_outputs_enable,
   output logic current_reg_active,
   output logic fault_out_n,
   output logic [7:0] regulation_target,
   output logic [1:0] speed_scale,
   output logic speed_reg_mode,
   output logic voltage_reg_mode,
   output logic signed [8:0] speed_error,
   output logic adc_sample
);
   // ==========================================================================
   // Registers.
   mstd_pkg::mstd_ctrl_t ctrl_ff;
   logic [15:0] inrush_blank_count_ff;
   logic [7:0] target_ff;
   logic sleep_ff;
   logic aw_ff, w_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_go;
   logic clear_fault;
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic nxt_rok;

   assign s_axi_awready = !aw_ff && !bvalid_ff;
   assign s_axi_wready = !w_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign wr_go = aw_ff && w_ff && !bvalid_ff;
   assign clear_fault = wr_go && awaddr_ff == mstd_pkg::cmd_off && wstrb_ff[0] &&
                        wdata_ff[mstd_pkg::clear_bit];
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            w_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= mstd_pkg::axi_okay;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         unique case (awaddr_ff)
            mstd_pkg::ctrl_off, mstd_pkg::inrush_off, mstd_pkg::reg_off, mstd_pkg::cmd_off,
            mstd_pkg::status_off, mstd_pkg::speed_off: bresp_ff <= mstd_pkg::axi_okay;
            default: bresp_ff <= mstd_pkg::axi_slverr;
         endcase
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= '{scale: mstd_pkg::scale_rst, regctl: mstd_pkg::regctl_rst,
                      current_reg_mode: mstd_pkg::current_reg_mode_rst, default: 1'b0};
         inrush_blank_count_ff <= mstd_pkg::inrush_rst;
         target_ff <= mstd_pkg::target_rst;
         sleep_ff <= 1'b0;
      end else if (wr_go) begin
         if (awaddr_ff == mstd_pkg::ctrl_off) begin
            if (wstrb_ff[0]) begin
               ctrl_ff.int_vref <= wdata_ff[mstd_pkg::int_vref_bit];
               ctrl_ff.stall_en <= wdata_ff[mstd_pkg::stall_en_bit];
               ctrl_ff.stall_response_select <= wdata_ff[mstd_pkg::stall_response_select_bit];
               ctrl_ff.report <= wdata_ff[mstd_pkg::report_bit];
               ctrl_ff.softstart <= wdata_ff[mstd_pkg::softstart_bit];
            end
            if (wstrb_ff[1]) begin
               ctrl_ff.current_reg_mode <= wdata_ff[mstd_pkg::current_reg_mode_lsb +: 2];
               ctrl_ff.regctl <= wdata_ff[mstd_pkg::regctl_lsb +: 2];
            end
            if (wstrb_ff[2]) begin
               ctrl_ff.scale <= wdata_ff[mstd_pkg::scale_lsb +: 2];
            end
         end
         if (awaddr_ff == mstd_pkg::inrush_off) begin
            if (wstrb_ff[0]) begin
               inrush_blank_count_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
               inrush_blank_count_ff[15:8] <= wdata_ff[15:8];
            end
         end
         if (awaddr_ff == mstd_pkg::reg_off && wstrb_ff[0]) begin
            target_ff <= wdata_ff[7:0];
         end
         if (awaddr_ff == mstd_pkg::cmd_off && wstrb_ff[0]) begin
            sleep_ff <= wdata_ff[mstd_pkg::sleep_bit];
         end
      end
   end

   // ==========================================================================
   // Comparator synchronisers and reference choice.
   logic [2:0] ext_sync_ff, int_sync_ff, flt_sync_ff;
   logic ext_ff, int_ff, flt_ff;
   logic trip;
   logic fault_rise;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync_ff <= 3'h0;
         int_sync_ff <= 3'h0;
         flt_sync_ff <= 3'h0;
         ext_ff <= 1'b0;
         int_ff <= 1'b0;
         flt_ff <= 1'b0;
      end else begin
         ext_sync_ff <= {ext_sync_ff[1:0], sense_ge_ext_ref};
         int_sync_ff <= {int_sync_ff[1:0], sense_ge_int_ref};
         flt_sync_ff <= {flt_sync_ff[1:0], fault_event};
         if (ext_sync_ff[1] == ext_sync_ff[2]) begin
            ext_ff <= ext_sync_ff[2];
         end
         if (int_sync_ff[1] == int_sync_ff[2]) begin
            int_ff <= int_sync_ff[2];
         end
         if (flt_sync_ff[1] == flt_sync_ff[2]) begin
            flt_ff <= flt_sync_ff[2];
         end
      end
   end

   // Sense at or above the chosen reference is the trip condition.
   assign trip = ctrl_ff.int_vref ? int_ff : ext_ff;
   assign fault_rise = flt_sync_ff[2] && !flt_ff && flt_sync_ff[1];

   // ==========================================================================
   // Inrush blanking timer and stall state.
   mstd_pkg::mstd_state_t state_ff;
   logic [31:0] base_cnt_ff;
   logic [15:0] tick_cnt_ff;
   logic [15:0] blank_cnt_ff;
   logic in_base_ff;
   logic stall_flag_ff;
   logic restart;
   logic blank_done;
   logic sleep_d_ff;

   // Blanking restarts on a fault, on leaving sleep, and on stall recovery.
   assign restart = fault_rise || (sleep_d_ff && !sleep_ff) || clear_fault;
   assign blank_done = !in_base_ff && blank_cnt_ff == inrush_blank_count_ff &&
                       tick_cnt_ff == 16'(tick_cycles - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_d_ff <= 1'b0;
      end else begin
         sleep_d_ff <= sleep_ff;
      end
   end

   // The interval is a fixed base plus one tick per count and one tick more; the count is read
   // live, so reprogramming it mid-interval moves the end point.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_cnt_ff <= 32'h0;
         tick_cnt_ff <= 16'h0;
         blank_cnt_ff <= 16'h0;
         in_base_ff <= 1'b1;
      end else if (restart || state_ff != mstd_pkg::mstd_blank || sleep_ff) begin
         base_cnt_ff <= 32'h0;
         tick_cnt_ff <= 16'h0;
         blank_cnt_ff <= 16'h0;
         in_base_ff <= 1'b1;
      end else if (in_base_ff) begin
         base_cnt_ff <= base_cnt_ff + 32'h1;
         if (base_cnt_ff == 32'(base_cycles - 1)) begin
            in_base_ff <= 1'b0;
         end
      end else if (tick_cnt_ff == 16'(tick_cycles - 1)) begin
         tick_cnt_ff <= 16'h0;
         blank_cnt_ff <= blank_cnt_ff + 16'h1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= mstd_pkg::mstd_blank;
      end else if (restart || sleep_ff) begin
         state_ff <= mstd_pkg::mstd_blank;
      end else begin
         unique case (state_ff)
            mstd_pkg::mstd_blank: if (blank_done) begin
               state_ff <= mstd_pkg::mstd_watch;
            end
            mstd_pkg::mstd_watch: if (ctrl_ff.stall_en && trip) begin
               state_ff <= mstd_pkg::mstd_stalled;
            end
            mstd_pkg::mstd_stalled: state_ff <= mstd_pkg::mstd_stalled;
         endcase
      end
   end

   // A stall in the same cycle as a clear is dropped: the clear wins and sends the
   // machine back to blanking, so the event is lost to it and must trip again after blanking.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stall_flag_ff <= 1'b0;
      end else if (state_ff == mstd_pkg::mstd_watch && ctrl_ff.stall_en && trip && !restart) begin
         stall_flag_ff <= 1'b1;
      end else if (clear_fault) begin
         stall_flag_ff <= 1'b0;
      end
   end

   // ==========================================================================
   // Pin outputs.
   logic nxt_creg;
   always_comb begin
      unique case (ctrl_ff.current_reg_mode)
         mstd_pkg::current_reg_mode_off: nxt_creg = 1'b0;
         mstd_pkg::current_reg_mode_inrush: nxt_creg = trip && (!ctrl_ff.stall_en ||
                                          state_ff == mstd_pkg::mstd_blank);
         default: nxt_creg = trip;
      endcase
   end

   logic [$clog2(mstd_pkg::adc_cyc)-1:0] adc_cnt_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc_cnt_ff <= '0;
         adc_sample <= 1'b0;
      end else begin
         adc_sample <= adc_cnt_ff == '0;
         adc_cnt_ff <= (adc_cnt_ff == ($clog2(mstd_pkg::adc_cyc))'(mstd_pkg::adc_cyc - 1)) ? '0 :
                       adc_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_internal_sel <= 1'b0;
         bridge_outputs_enable <= 1'b1;
         current_reg_active <= 1'b0;
         fault_out_n <= 1'b1;
         regulation_target <= mstd_pkg::target_rst;
         speed_scale <= mstd_pkg::scale_rst;
         speed_reg_mode <= 1'b0;
         voltage_reg_mode <= 1'b0;
         speed_error <= 9'sh0;
      end else begin
         ref_internal_sel <= ctrl_ff.int_vref;
         // Outputs stay latched off only while a latched-mode stall is held.
         bridge_outputs_enable <= !(state_ff == mstd_pkg::mstd_stalled &&
                                    !ctrl_ff.stall_response_select);
         current_reg_active <= nxt_creg;
         fault_out_n <= !(ctrl_ff.report && stall_flag_ff);
         regulation_target <= target_ff;
         speed_scale <= ctrl_ff.scale;
         speed_reg_mode <= ctrl_ff.regctl == mstd_pkg::regctl_speed;
         voltage_reg_mode <= ctrl_ff.regctl == mstd_pkg::regctl_volt;
         if (adc_cnt_ff == '0) begin
            speed_error <= $signed({1'b0, target_ff}) - $signed({1'b0, speed_estimate});
         end
      end
   end

   // ==========================================================================
   // Register read.
   always_comb begin
      nxt_rdata = 32'h0;
      nxt_rok = 1'b1;
      unique case (s_axi_araddr)
         mstd_pkg::ctrl_off: nxt_rdata = {14'h0, ctrl_ff.scale, 2'h0, ctrl_ff.regctl, 2'h0,
                                          ctrl_ff.current_reg_mode, 3'h0, ctrl_ff.softstart, ctrl_ff.report,
                                          ctrl_ff.stall_response_select, ctrl_ff.stall_en, ctrl_ff.int_vref};
         mstd_pkg::inrush_off: nxt_rdata = {16'h0, inrush_blank_count_ff};
         mstd_pkg::reg_off: nxt_rdata = {24'h0, target_ff};
         mstd_pkg::cmd_off: nxt_rdata = {30'h0, sleep_ff, 1'b0};
         mstd_pkg::status_off: nxt_rdata = {26'h0, int_ff, ext_ff, current_reg_active,
                                            state_ff == mstd_pkg::mstd_blank,
                                            !bridge_outputs_enable, stall_flag_ff};
         mstd_pkg::speed_off: nxt_rdata = {24'h0, speed_estimate};
         default: nxt_rok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= mstd_pkg::axi_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rok ? mstd_pkg::axi_okay : mstd_pkg::axi_slverr;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ==========================================================================
   // Checks.
   sequence stall_seen;
      state_ff == mstd_pkg::mstd_watch && ctrl_ff.stall_en && trip && !restart && aresetn && !sleep_ff;
   endsequence
   chk_stall_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      stall_seen |=> stall_flag_ff) else $error("stall did not set flag");
   chk_no_stall_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_ff.stall_en && !stall_flag_ff |=> !stall_flag_ff) else $error("flag set while disabled");
   chk_blank_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      state_ff == mstd_pkg::mstd_blank && !stall_flag_ff |=> !stall_flag_ff) else $error("flag during blank");
   chk_latch_off: assert property (@(posedge aclk) disable iff (!aresetn)
      state_ff == mstd_pkg::mstd_stalled && !ctrl_ff.stall_response_select |=> !bridge_outputs_enable)
      else $error("outputs not disabled");
   chk_indicate_only: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_ff.stall_response_select |=> bridge_outputs_enable) else $error("outputs dropped in indicate mode");
   chk_clear_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_fault |=> !stall_flag_ff ##1 bridge_outputs_enable) else $error("clear fault ignored");
   chk_fault_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 fault_out_n == !($past(ctrl_ff.report) && $past(stall_flag_ff))) else $error("fault pin wrong");
   chk_creg_inrush: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_ff.current_reg_mode == mstd_pkg::current_reg_mode_inrush && ctrl_ff.stall_en &&
      state_ff != mstd_pkg::mstd_blank |=> !current_reg_active) else $error("regulation outside inrush");
   chk_creg_always: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_ff.current_reg_mode == mstd_pkg::current_reg_mode_inrush && !ctrl_ff.stall_en && trip
      |=> current_reg_active)
      else $error("regulation missing");
   chk_restart_blank: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> state_ff == mstd_pkg::mstd_blank [*2]) else $error("blank not restarted");
endmodule
`default_nettype wire

// ---- tb/mstd_partner.sv ----
// Behavioural model of the current-sense comparators that face the stall detector.
`timescale 1ns/1ps
`default_nettype none
module mstd_partner #(
   parameter logic [7:0] int_ref_code = 8'h1e
) (
   input wire logic [7:0] sense_level,
   input wire logic [7:0] ext_ref_level,
   output logic sense_ge_ext_ref,
   output logic sense_ge_int_ref
);
   // ==========================================================================
   // Comparators.
   // Both trip on equality too, so a level exactly at the reference counts as a trip.
   assign sense_ge_ext_ref = (sense_level >= ext_ref_level);
   assign sense_ge_int_ref = (sense_level >= int_ref_code);
endmodule
`default_nettype wire

// ---- tb/tb_motor_stall_detector.sv ----
// Self-checking testbench of the motor stall detector.
`timescale 1ns/1ps
`default_nettype none
module tb_motor_stall_detector;
   // ==========================================================================
   // Signals.
   // Short timer parameters keep each blanking interval to a few dozen cycles.
   localparam int tk = 4;
   localparam int bs = 10;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awv = 1'b0, awr, wv = 1'b0, wr, bv, bre = 1'b0, arv = 1'b0, arr, rv, rre = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, spd = 8'h00, lvl = 8'h00, eref = 8'h80, tgt;
   logic [31:0] wd = 32'h0, rdt, rd;
   logic [1:0] br, rr, rs, scl;
   logic gex, gin, rsel, bren, creg, fn, smd, vmd, adc;
   logic flt = 1'b0;
   logic signed [8:0] serr;
   int failures = 0;
   int comparisons = 0;
   mstd_top #(.tick_cycles(tk), .base_cycles(bs)) i_mstd_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdt), .s_axi_rresp(rr), .sense_ge_ext_ref(gex),
      .sense_ge_int_ref(gin), .fault_event(flt), .speed_estimate(spd), .ref_internal_sel(rsel),
      .bridge_outputs_enable(bren), .current_reg_active(creg), .fault_out_n(fn), .regulation_target(tgt),
      .speed_scale(scl), .speed_reg_mode(smd), .voltage_reg_mode(vmd), .speed_error(serr), .adc_sample(adc));
   mstd_partner i_mstd_partner (.sense_level(lvl), .ext_ref_level(eref), .sense_ge_ext_ref(gex),
      .sense_ge_int_ref(gin));
   always #12.5 aclk = ~aclk;
   // ==========================================================================
   // Shared tasks.
   task automatic final_report();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   function automatic int ivl(input int c);
      return bs + (c + 1) * tk;
   endfunction
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ap;
      logic wp;
      @(posedge aclk);
      ap = 1'b1;
      wp = 1'b1;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (ap || wp) begin
         @(posedge aclk);
         if (ap && awr) begin
            ap = 1'b0;
            awv <= 1'b0;
         end
         if (wp && wr) begin
            wp = 1'b0;
            wv <= 1'b0;
         end
      end
      do @(posedge aclk); while (bv !== 1'b1);
      rs = br;
      bre <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      rd = rdt;
      rs = rr;
      rre <= 1'b0;
   endtask
   // Waits for the fault pin (sel high) or the bridge enable to drop, counting cycles.
   task automatic wait_low(input logic sel, output int n);
      n = 0;
      while (((sel ? fn : bren) !== 1'b0) && n < 300) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic arm(input logic [31:0] c, input logic [15:0] t);
      axw(8'h04, {16'h0, t});
      axw(8'h00, c);
      lvl <= 8'hc0;
      axw(8'h0c, 32'h1);
   endtask
   task automatic clr();
      lvl <= 8'h00;
      axw(8'h0c, 32'h1);
      repeat (2) @(posedge aclk);
   endtask
   // ==========================================================================
   // Scenarios.
   task automatic t_reset();
      chk({bren, fn}, 2'h3, "pins at reset");
      axr(8'h04);
      chk(rd, 32'h25b8, "inrush reset");
      axr(8'h24);
      chk(rd, 32'h0, "unmapped read data");
      chk(rs, mstd_pkg::axi_slverr, "unmapped read");
      axw(8'h24, 32'h1);
      chk(rs, mstd_pkg::axi_slverr, "unmapped write");
   endtask
   task automatic t_latched();
      int n;
      for (int c = 0; c < 6; c += 5) begin
         arm(32'h2, 16'(c));
         wait_low(1'b0, n);
         chk(n >= ivl(c) - 1 && n <= ivl(c) + 12, 1'b1, "latch time");
         chk(fn, 1'b1, "not reported");
         axr(8'h10);
         chk(rd[1:0], 2'h3, "latched flag");
         clr();
         chk(bren, 1'b1, "latch release");
         axr(8'h10);
         chk(rd[2:0], 3'h4, "cleared blanking");
      end
   endtask
   task automatic t_indicate();
      int n;
      arm(32'he, 16'h0000);
      wait_low(1'b1, n);
      chk(n >= ivl(0) - 1 && n <= ivl(0) + 12, 1'b1, "report time");
      chk(bren, 1'b1, "keeps driving");
      axr(8'h10);
      chk(rd[1:0], 2'h1, "flag only");
      clr();
      chk(fn, 1'b1, "pin released");
      repeat (ivl(0) + 4) @(posedge aclk);
      axr(8'h10);
      chk(rd[2], 1'b0, "watching before fault");
      flt <= 1'b1;
      repeat (6) @(posedge aclk);
      flt <= 1'b0;
      axr(8'h10);
      chk(rd[2], 1'b1, "fault restarts blank");
      axw(8'h0c, 32'h2);
      repeat (ivl(0) + 4) @(posedge aclk);
      axr(8'h10);
      chk(rd[2], 1'b1, "sleep holds blank");
      axw(8'h0c, 32'h0);
      repeat (ivl(0) + 4) @(posedge aclk);
      axr(8'h10);
      chk(rd[2], 1'b0, "blank ends after wake");
   endtask
   task automatic t_disabled();
      arm(32'h100, 16'h0000);
      repeat (ivl(0) + 15) @(posedge aclk);
      chk({creg, fn, bren}, 3'h7, "disabled");
      arm(32'h106, 16'h0005);
      repeat (6) @(posedge aclk);
      chk(creg, 1'b1, "reg in inrush");
      repeat (ivl(5) + 10) @(posedge aclk);
      chk(creg, 1'b0, "reg after inrush");
      clr();
   endtask
   task automatic t_intref();
      int n;
      eref <= 8'hff;
      arm(32'hf, 16'h0000);
      chk(rsel, 1'b1, "internal select");
      wait_low(1'b1, n);
      chk(n <= ivl(0) + 12, 1'b1, "internal trip");
      arm(32'he, 16'h0000);
      repeat (ivl(0) + 15) @(posedge aclk);
      chk({rsel, fn}, 2'h1, "external below");
      eref <= 8'hc0;
      axw(8'h0c, 32'h1);
      wait_low(1'b1, n);
      chk(n <= ivl(0) + 12, 1'b1, "equal trips");
      clr();
      eref <= 8'h80;
   endtask
   task automatic t_regul();
      int n;
      spd <= 8'h20;
      axw(8'h08, 32'h5a);
      for (int k = 0; k < 4; k++) begin
         axw(8'h00, (32'(k) << 12) | (32'(3 - k) << 16));
         repeat (2) @(posedge aclk);
         chk({smd, vmd, scl, tgt}, {k == 2, k == 3, 2'(3 - k), 8'h5a}, "reg config");
      end
      axw(8'h00, 32'h2000);
      axr(8'h00);
      chk(rd, 32'h2000, "ctrl readback");
      axr(8'h14);
      chk(rd, 32'h20, "speed readback");
      do @(posedge aclk); while (adc !== 1'b1);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (adc !== 1'b1 && n < 600);
      chk(n, 500, "adc period");
      repeat (2) @(posedge aclk);
      chk(serr, 32'd58, "speed error");
   endtask
   // ==========================================================================
   // Sequence and watchdog.
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_latched();
      t_indicate();
      t_disabled();
      t_intref();
      t_regul();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
